// ==== verilog/pmwc_pkg.sv ====
// Constants, register map and field layouts for the power mode and wake-up controller.
// Assumes a single 10 MHz bus clock; all timings below are derived from that period.
package pmwc_pkg;

  // Edge wake lines: 16 pin lines, then supply detector, timekeeper alarm and one spare
  localparam int unsigned LINES       = 19;
  localparam int unsigned EXT_LINES   = 16;
  localparam int unsigned LINE_SUPPLY = 16;
  localparam int unsigned LINE_RTC    = 17;
  localparam int unsigned LINE_AUX    = 18;

  // Register byte offsets
  localparam logic [7:0] RISE_OFS  = 8'h00;
  localparam logic [7:0] FALL_OFS  = 8'h04;
  localparam logic [7:0] IMASK_OFS = 8'h08;
  localparam logic [7:0] EMASK_OFS = 8'h0C;
  localparam logic [7:0] PEND_OFS  = 8'h10;
  localparam logic [7:0] CTRL_OFS  = 8'h14;
  localparam logic [7:0] STAT_OFS  = 8'h18;
  localparam logic [7:0] ISTAT_OFS = 8'h1C;
  localparam logic [7:0] IMSK_OFS  = 8'h20;

  // Control word: bit 0 is the write-only entry strobe, bits 9:1 hold pmwc_ctrl_t
  localparam int unsigned CTRL_ENTER_BIT = 0;
  localparam int unsigned CTRL_LSB       = 1;
  localparam int unsigned CTRL_MSB       = 9;

  localparam logic [1:0] MODE_SLEEP   = 2'h1;
  localparam logic [1:0] MODE_STOP    = 2'h2;
  localparam logic [1:0] MODE_STANDBY = 2'h3;

  typedef struct packed {
    logic [2:0] lvl_sel;
    logic       ext_osc_on;
    logic       ext_clk_sel;
    logic       stop_lp;
    logic       det_en;
    logic [1:0] mode;
  } pmwc_ctrl_t;

  localparam pmwc_ctrl_t CTRL_RST = '0;

  // Block status bits
  localparam int unsigned STAT_SLEEP   = 0;
  localparam int unsigned STAT_STOP    = 1;
  localparam int unsigned STAT_CLK_EXT = 2;
  localparam int unsigned STAT_BELOW   = 3;
  localparam int unsigned STAT_OSC_RDY = 4;

  // Sticky interrupt status bits
  localparam int unsigned IRQ_W        = 5;
  localparam int unsigned IRQ_SUP_FALL = 0;
  localparam int unsigned IRQ_SUP_RISE = 1;
  localparam int unsigned IRQ_CLK_FAIL = 2;
  localparam int unsigned IRQ_STOP_WK  = 3;
  localparam int unsigned IRQ_STBY_WK  = 4;

  // Timing
  localparam int unsigned CLK_PERIOD_NS   = 100;
  localparam int unsigned RST_HOLD_NS     = 20000;
  localparam int unsigned RST_HOLD_CYC    = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CSS_TIMEOUT_NS  = 5000;
  localparam int unsigned CSS_TIMEOUT_CYC = CSS_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int unsigned CNT_W           = 12;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_SLEEP,
    ST_STOP,
    ST_STANDBY,
    ST_WAKE_RST
  } pmwc_state_t;

  typedef struct packed {
    logic       cpu_clk_en;
    logic       core_clk_en;
    logic       pll_en;
    logic       int_osc_en;
    logic       ext_osc_en;
    logic       sysclk_ext;
    logic       reg_en;
    logic       reg_main;
    logic       reg_lp;
    logic       core_pwr_en;
    logic       lowspeed_en;
    logic       det_en;
    logic [2:0] det_lvl;
  } pmwc_pwr_t;

  localparam pmwc_pwr_t PWR_RST = '{cpu_clk_en: 1'b1, core_clk_en: 1'b1, pll_en: 1'b0,
                                    int_osc_en: 1'b1, ext_osc_en: 1'b0, sysclk_ext: 1'b0,
                                    reg_en: 1'b1, reg_main: 1'b1, reg_lp: 1'b0,
                                    core_pwr_en: 1'b1, lowspeed_en: 1'b1, det_en: 1'b0,
                                    det_lvl: 3'h0};

endpackage

// ==== verilog/pmwc_top.sv ====
// Power mode and wake-up controller: edge wake lines, supply detector, clock monitor,
// low-power mode sequencing, with an AHB-Lite register slave.
// Assumes all inputs synchronous to hclk except the raw wake lines, which are edge-captured.
//
// What this block does
// - Nineteen edge-detecting lines, each raising interrupt or event requests.
// - Per line, rising/falling/both trigger select and independent masking.
// - Pending register records lines with outstanding interrupt requests.
// - Line edges are caught even when narrower than one clock period.
// - Sixteen of the lines are external pin lines.
// - Reset held while main supply is below its threshold, always active.
// - Software-enabled supply detector interrupts on falling below or rising above.
// - Regulator main in Run, low-power in Stop when stop_lp is set, powered down in Standby.
// - Regulator enabled after every reset, disabled only in Standby.
// - Sleep stops only the processor clock; any interrupt or event wakes it.
// - Stop gates core clocks, PLL and fast oscillators; regulator per setting.
// - Stop exits on any edge line with its interrupt or event mask set: pins, supply detector or alarm.
// - Standby powers off the core domain, PLL and fast oscillators.
// - Standby exits only on reset pin, watchdog reset, wake pin rise, alarm.
// - Timekeeper, watchdog and their slow clocks keep running in Stop and Standby.
// - After reset the processor runs from the internal fast oscillator.
// - Selected external clock monitored; on failure revert and flag an interrupt.
`timescale 1ns/1ps

module pmwc_top
  import pmwc_pkg::*;
#(
  parameter int unsigned RST_HOLD    = RST_HOLD_CYC,
  parameter int unsigned CSS_TIMEOUT = CSS_TIMEOUT_CYC
) (
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 ce,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic [31:0]               hrdata,
  output logic                      hresp,
  input  wire logic [EXT_LINES-1:0] gpio_lines,
  input  wire logic                 line_aux,
  input  wire logic                 rtc_alarm,
  input  wire logic                 supply_below,
  input  wire logic                 supply_ok,
  input  wire logic                 external_reset_pin_n,
  input  wire logic                 always_on_watchdog_rst,
  input  wire logic                 standby_wake_pin,
  input  wire logic                 periph_irq,
  input  wire logic                 ext_osc_ready,
  input  wire logic                 ext_osc_tick,
  output logic                      irq,
  output logic                      evt_pulse,
  output pmwc_pwr_t                 pwr,
  output logic                      sys_reset_n
);

  if (RST_HOLD < 1 || RST_HOLD >= (1 << CNT_W)) begin : g_chk_hold
    $error("RST_HOLD out of range");
  end
  if (CSS_TIMEOUT < 1 || CSS_TIMEOUT >= (1 << CNT_W)) begin : g_chk_css
    $error("CSS_TIMEOUT out of range");
  end

  logic [LINES-1:0] line_raw;
  logic [LINES-1:0] rise_ev;
  logic [LINES-1:0] fall_ev;
  logic [LINES-1:0] hit;
  logic [LINES-1:0] rise_sel_q;
  logic [LINES-1:0] fall_sel_q;
  logic [LINES-1:0] imask_q;
  logic [LINES-1:0] emask_q;
  logic [LINES-1:0] pend_q;
  logic [IRQ_W-1:0] istat_q;
  logic [IRQ_W-1:0] imsk_q;
  logic [IRQ_W-1:0] istat_set;
  pmwc_ctrl_t       ctrl_q;
  pmwc_ctrl_t       ctrl_wr;
  pmwc_state_t      state_q;
  logic [CNT_W-1:0] hold_cnt_q;
  logic [CNT_W-1:0] css_cnt_q;
  pmwc_pwr_t        pwr_d;
  logic             wr_pend_q;
  logic [7:0]       wr_addr_q;
  logic [31:0]      rd_data;
  logic             wr_en;
  logic             below_q;
  logic             wake_pin_q;
  logic             enter_req;
  logic             sleep_wake;
  logic             stop_wake;
  logic             stby_wake;
  logic             css_fail;
  logic             cfg_lost;

  assign line_raw = {line_aux, rtc_alarm, supply_below, gpio_lines};

  // Each edge flips a toggle clocked by the line itself, so a pulse shorter than hclk still
  // leaves a trace; the toggle then crosses into hclk through two flops.
  for (genvar i = 0; i < LINES; i++) begin : g_line
    logic       rt_q;
    logic       ft_q;
    logic [2:0] rs_q;
    logic [2:0] fs_q;

    always_ff @(posedge line_raw[i] or negedge hresetn) begin
      if (!hresetn) begin
        rt_q <= 1'b0;
      end else begin
        rt_q <= ~rt_q;
      end
    end

    always_ff @(negedge line_raw[i] or negedge hresetn) begin
      if (!hresetn) begin
        ft_q <= 1'b0;
      end else begin
        ft_q <= ~ft_q;
      end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        rs_q <= 3'h0;
        fs_q <= 3'h0;
      end else if (ce) begin
        rs_q <= {rs_q[1:0], rt_q};
        fs_q <= {fs_q[1:0], ft_q};
      end
    end

    assign rise_ev[i] = rs_q[2] ^ rs_q[1];
    assign fall_ev[i] = fs_q[2] ^ fs_q[1];
  end

  assign hit = (rise_ev & rise_sel_q) | (fall_ev & fall_sel_q);

  // AHB-Lite slave: zero wait states, read data captured in the address phase
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign wr_en     = wr_pend_q;
  assign ctrl_wr   = pmwc_ctrl_t'(hwdata[CTRL_MSB:CTRL_LSB]);
  assign enter_req = wr_en && (wr_addr_q == CTRL_OFS) && hwdata[CTRL_ENTER_BIT] && (state_q == ST_RUN);

  always_comb begin
    rd_data = 32'h0;
    case ({haddr[7:2], 2'b00})
      RISE_OFS:  rd_data[LINES-1:0] = rise_sel_q;
      FALL_OFS:  rd_data[LINES-1:0] = fall_sel_q;
      IMASK_OFS: rd_data[LINES-1:0] = imask_q;
      EMASK_OFS: rd_data[LINES-1:0] = emask_q;
      PEND_OFS:  rd_data[LINES-1:0] = pend_q;
      CTRL_OFS:  rd_data[CTRL_MSB:CTRL_LSB] = ctrl_q;
      STAT_OFS: begin
        rd_data[STAT_SLEEP]   = (state_q == ST_SLEEP);
        rd_data[STAT_STOP]    = (state_q == ST_STOP);
        rd_data[STAT_CLK_EXT] = pwr.sysclk_ext;
        rd_data[STAT_BELOW]   = below_q;
        rd_data[STAT_OSC_RDY] = ext_osc_ready;
      end
      ISTAT_OFS: rd_data[IRQ_W-1:0] = istat_q;
      IMSK_OFS:  rd_data[IRQ_W-1:0] = imsk_q;
      default:   rd_data = 32'h0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata    <= 32'h0;
    end else if (ce && hready) begin
      wr_pend_q <= hsel && htrans[1] && hwrite;
      wr_addr_q <= {haddr[7:2], 2'b00};
      if (hsel && htrans[1] && !hwrite) begin
        hrdata <= rd_data;
      end
    end
  end

  // Core-domain configuration is lost while the core is unpowered
  assign cfg_lost = (state_q == ST_STANDBY);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rise_sel_q <= '0;
      fall_sel_q <= '0;
      imask_q    <= '0;
      emask_q    <= '0;
    end else if (ce) begin
      if (cfg_lost) begin
        rise_sel_q <= '0;
        fall_sel_q <= '0;
        imask_q    <= '0;
        emask_q    <= '0;
      end else if (wr_en) begin
        if (wr_addr_q == RISE_OFS) rise_sel_q <= hwdata[LINES-1:0];
        if (wr_addr_q == FALL_OFS) fall_sel_q <= hwdata[LINES-1:0];
        if (wr_addr_q == IMASK_OFS) imask_q <= hwdata[LINES-1:0];
        if (wr_addr_q == EMASK_OFS) emask_q <= hwdata[LINES-1:0];
      end
    end
  end

  // Pending: write one to clear, a new edge in the same cycle wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_q <= '0;
    end else if (ce) begin
      if (cfg_lost) begin
        pend_q <= '0;
      end else if (wr_en && wr_addr_q == PEND_OFS) begin
        pend_q <= (pend_q & ~hwdata[LINES-1:0]) | (hit & imask_q);
      end else begin
        pend_q <= pend_q | (hit & imask_q);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      evt_pulse <= 1'b0;
    end else if (ce) begin
      evt_pulse <= |(hit & emask_q);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= CTRL_RST;
    end else if (ce) begin
      if (cfg_lost) begin
        ctrl_q <= CTRL_RST;
      end else begin
        if (wr_en && wr_addr_q == CTRL_OFS) begin
          ctrl_q <= ctrl_wr;
        end
        if (css_fail || (state_q == ST_STOP && stop_wake)) begin
          ctrl_q.ext_clk_sel <= 1'b0;
        end
      end
    end
  end

  // Supply detector compare result and wake pin history
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      below_q    <= 1'b0;
      wake_pin_q <= 1'b0;
    end else if (ce) begin
      below_q    <= supply_below;
      wake_pin_q <= standby_wake_pin;
    end
  end

  // External clock monitor: no activity tick for CSS_TIMEOUT cycles means failure
  assign css_fail = ctrl_q.ext_clk_sel && (css_cnt_q == CNT_W'(CSS_TIMEOUT));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      css_cnt_q <= '0;
    end else if (ce) begin
      if (!ctrl_q.ext_clk_sel || ext_osc_tick) begin
        css_cnt_q <= '0;
      end else if (css_cnt_q != CNT_W'(CSS_TIMEOUT)) begin
        css_cnt_q <= css_cnt_q + CNT_W'(1);
      end
    end
  end

  always_comb begin
    istat_set                = '0;
    istat_set[IRQ_SUP_FALL]  = ctrl_q.det_en && supply_below && !below_q;
    istat_set[IRQ_SUP_RISE]  = ctrl_q.det_en && !supply_below && below_q;
    istat_set[IRQ_CLK_FAIL]  = css_fail;
    istat_set[IRQ_STOP_WK]   = (state_q == ST_STOP) && stop_wake;
    istat_set[IRQ_STBY_WK]   = (state_q == ST_STANDBY) && stby_wake;
  end

  // Status is standby circuitry and survives; masks are lost with the core domain
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      istat_q <= '0;
      imsk_q  <= '0;
    end else if (ce) begin
      if (wr_en && wr_addr_q == ISTAT_OFS) begin
        istat_q <= (istat_q & ~hwdata[IRQ_W-1:0]) | istat_set;
      end else begin
        istat_q <= istat_q | istat_set;
      end
      if (cfg_lost) begin
        imsk_q <= '0;
      end else if (wr_en && wr_addr_q == IMSK_OFS) begin
        imsk_q <= hwdata[IRQ_W-1:0];
      end
    end
  end

  assign irq = (|pend_q) || (|(istat_q & imsk_q));

  assign sleep_wake = irq || periph_irq || (|(hit & emask_q));
  assign stop_wake  = |(hit & (imask_q | emask_q));
  assign stby_wake  = !external_reset_pin_n || always_on_watchdog_rst ||
                      (standby_wake_pin && !wake_pin_q) || rise_ev[LINE_RTC];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q    <= ST_RUN;
      hold_cnt_q <= '0;
    end else if (ce) begin
      case (state_q)
        ST_RUN: begin
          if (enter_req) begin
            case (ctrl_wr.mode)
              MODE_SLEEP:   state_q <= ST_SLEEP;
              MODE_STOP:    state_q <= ST_STOP;
              MODE_STANDBY: state_q <= ST_STANDBY;
              default:      state_q <= ST_RUN;
            endcase
          end
        end
        ST_SLEEP: begin
          if (sleep_wake) state_q <= ST_RUN;
        end
        ST_STOP: begin
          if (stop_wake) state_q <= ST_RUN;
        end
        ST_STANDBY: begin
          if (stby_wake) begin
            state_q    <= ST_WAKE_RST;
            hold_cnt_q <= '0;
          end
        end
        ST_WAKE_RST: begin
          if (hold_cnt_q == CNT_W'(RST_HOLD - 1)) begin
            state_q <= ST_RUN;
          end else begin
            hold_cnt_q <= hold_cnt_q + CNT_W'(1);
          end
        end
        default: state_q <= ST_RUN;
      endcase
    end
  end

  // Power and clock controls, registered so the analog side never sees decode glitches
  always_comb begin
    pwr_d             = PWR_RST;
    pwr_d.cpu_clk_en  = (state_q == ST_RUN);
    pwr_d.core_clk_en = (state_q == ST_RUN) || (state_q == ST_SLEEP);
    pwr_d.pll_en      = pwr_d.core_clk_en && ctrl_q.ext_clk_sel;
    pwr_d.int_osc_en  = pwr_d.core_clk_en;
    pwr_d.ext_osc_en  = pwr_d.core_clk_en && ctrl_q.ext_osc_on;
    pwr_d.sysclk_ext  = pwr_d.core_clk_en && ctrl_q.ext_clk_sel && ext_osc_ready;
    pwr_d.reg_en      = (state_q != ST_STANDBY);
    pwr_d.reg_lp      = (state_q == ST_STOP) && ctrl_q.stop_lp;
    pwr_d.reg_main    = pwr_d.reg_en && !pwr_d.reg_lp;
    pwr_d.core_pwr_en = pwr_d.reg_en;
    pwr_d.lowspeed_en = 1'b1;
    pwr_d.det_en      = ctrl_q.det_en;
    pwr_d.det_lvl     = ctrl_q.lvl_sel;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwr <= PWR_RST;
    end else if (ce) begin
      pwr <= pwr_d;
    end
  end

  // Device reset: supply monitor cannot be disabled by software
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sys_reset_n <= 1'b0;
    end else if (ce) begin
      sys_reset_n <= supply_ok && external_reset_pin_n && !always_on_watchdog_rst &&
                     (state_q != ST_STANDBY) && (state_q != ST_WAKE_RST);
    end
  end

endmodule

// ==== bench/pmwc_sva.sv ====
// Checker for the power mode and wake-up controller, watching only the top ports.
// Assumes one hclk domain with hresetn as its asynchronous reset.
`timescale 1ns/1ps

module pmwc_sva
  import pmwc_pkg::*;
#(
  parameter int unsigned CSS_TIMEOUT = CSS_TIMEOUT_CYC
) (
  input wire logic      hclk,
  input wire logic      hresetn,
  input wire logic      ce,
  input wire logic      supply_ok,
  input wire logic      ext_osc_tick,
  input wire logic      hreadyout,
  input wire logic      hresp,
  input wire logic      evt_pulse,
  input wire pmwc_pwr_t pwr,
  input wire logic      sys_reset_n
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic [15:0] idle_q;
  // Cycles on the external clock with no activity; pwr lags the select by one edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idle_q <= 16'h0000;
    end else begin
      idle_q <= (pwr.sysclk_ext && !ext_osc_tick) ? idle_q + 16'h0001 : 16'h0000;
    end
  end

  property p_ready; hreadyout && !hresp; endproperty
  a_ready: assert property (p_ready) else $error("bus slave not ready or not okay");
  property p_run_reg; pwr.cpu_clk_en |-> pwr.reg_main && !pwr.reg_lp; endproperty
  a_run_reg: assert property (p_run_reg) else $error("run without main regulator");
  property p_stop_gate;
    !pwr.core_clk_en |-> !pwr.cpu_clk_en && !pwr.pll_en && !pwr.int_osc_en && !pwr.ext_osc_en;
  endproperty
  a_stop_gate: assert property (p_stop_gate) else $error("clock left running with core clocks gated");
  property p_reg_off; !pwr.reg_en |-> !pwr.core_pwr_en && !pwr.core_clk_en; endproperty
  a_reg_off: assert property (p_reg_off) else $error("regulator off outside standby");
  property p_stby_off;
    !pwr.core_pwr_en |-> !pwr.reg_en && !pwr.pll_en && !pwr.int_osc_en && !pwr.ext_osc_en;
  endproperty
  a_stby_off: assert property (p_stby_off) else $error("standby left something powered");
  property p_lowspeed; pwr.lowspeed_en; endproperty
  a_lowspeed: assert property (p_lowspeed) else $error("slow clock domain stopped");
  property p_supply; !supply_ok && ce |=> !sys_reset_n; endproperty
  a_supply: assert property (p_supply) else $error("low supply did not hold reset");
  property p_after_rst; !$past(hresetn) |-> pwr.reg_en && pwr.int_osc_en && !pwr.sysclk_ext; endproperty
  a_after_rst: assert property (p_after_rst) else $error("wrong clock or regulator after reset");
  property p_css; idle_q <= CSS_TIMEOUT + 2; endproperty
  a_css: assert property (p_css) else $error("dead external clock kept selected");

  c_sleep: cover property (!pwr.cpu_clk_en && pwr.core_clk_en);
  c_stop: cover property (!pwr.core_clk_en && pwr.core_pwr_en);
  c_stby: cover property (!pwr.core_pwr_en);
  c_evt: cover property (evt_pulse);
endmodule

bind pmwc_top pmwc_sva #(.CSS_TIMEOUT(CSS_TIMEOUT)) u_sva (
  .hclk(hclk), .hresetn(hresetn), .ce(ce), .supply_ok(supply_ok), .ext_osc_tick(ext_osc_tick),
  .hreadyout(hreadyout), .hresp(hresp), .evt_pulse(evt_pulse), .pwr(pwr), .sys_reset_n(sys_reset_n)
);

// ==== bench/pmwc_ext.sv ====
// Far-side model: wake lines, alarm, supply comparator and external oscillator.
// Assumes its tasks are called just after a rising hclk edge.
`timescale 1ns/1ps

module pmwc_ext (
  input  wire logic   hclk,
  output logic [15:0] gpio_lines,
  output logic        supply_below,
  output logic        rtc_alarm,
  output logic        line_aux,
  output logic        ext_osc_ready,
  output logic        ext_osc_tick = 1'b0
);
  logic [18:0] lines   = '0;
  logic        osc_run = 1'b0;

  assign gpio_lines    = lines[15:0];
  assign supply_below  = lines[16];
  assign rtc_alarm     = lines[17];
  assign line_aux      = lines[18];
  assign ext_osc_ready = osc_run;

  // Pulse far shorter than a clock period: missed by plain sampling
  task automatic pulse(input int i);
    #20 lines[i] = 1'b1;
    #10 lines[i] = 1'b0;
  endtask

  task automatic set_line(input int i, input logic v);
    lines[i] <= v;
  endtask

  always @(posedge hclk) begin
    ext_osc_tick <= osc_run;
  end
endmodule

// ==== bench/power_mode_wakeup_control_bench.sv ====
// Self-checking bench: AHB-Lite master tasks and one task per scenario.
// Assumes the checker is bound to pmwc_top and short counts of 4 cycles.
`timescale 1ns/1ps

module power_mode_wakeup_control_bench;
  import pmwc_pkg::*;
  localparam int unsigned CSS = 4;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, evt_pulse, sys_reset_n;
  logic        supply_ok, standby_wake_pin, periph_irq, rtc_alarm, line_aux, supply_below;
  logic        ce, rst_pin_n, wdog_rst;
  logic        ext_osc_ready, ext_osc_tick;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [15:0] gpio_lines;
  pmwc_pwr_t   pwr;
  int          n_mismatch, checked, n_evt;

  pmwc_top #(.RST_HOLD(4), .CSS_TIMEOUT(CSS)) dut (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .gpio_lines(gpio_lines), .line_aux(line_aux),
    .rtc_alarm(rtc_alarm), .supply_below(supply_below), .supply_ok(supply_ok),
    .external_reset_pin_n(rst_pin_n), .always_on_watchdog_rst(wdog_rst),
    .standby_wake_pin(standby_wake_pin), .periph_irq(periph_irq), .ext_osc_ready(ext_osc_ready),
    .ext_osc_tick(ext_osc_tick), .irq(irq), .evt_pulse(evt_pulse), .pwr(pwr), .sys_reset_n(sys_reset_n));

  pmwc_ext ext (
    .hclk(hclk), .gpio_lines(gpio_lines), .supply_below(supply_below), .rtc_alarm(rtc_alarm),
    .line_aux(line_aux), .ext_osc_ready(ext_osc_ready), .ext_osc_tick(ext_osc_tick));

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    if (evt_pulse === 1'b1) n_evt++;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  // Callers enter just after a rising edge, so the address phase starts there
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h000000, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic t_reset;
    chk(pwr, PWR_RST);
    rdchk(STAT_OFS, 32'h0);
    rdchk(8'h40, 32'h0);
  endtask

  task automatic t_lines;
    wr(RISE_OFS, 32'h7FFFF);
    wr(IMASK_OFS, 32'h7FFFF);
    for (int i = 0; i < 19; i++) begin
      ext.pulse(i);
      cyc(5);
      rdchk(PEND_OFS, 32'h1 << i);
      wr(PEND_OFS, 32'h1 << i);
    end
    wr(RISE_OFS, 32'h0);
    wr(FALL_OFS, 32'h4);
    ext.set_line(2, 1'b1);
    cyc(5);
    rdchk(PEND_OFS, 32'h0);
    ext.set_line(2, 1'b0);
    cyc(5);
    rdchk(PEND_OFS, 32'h4);
    wr(PEND_OFS, 32'h4);
    wr(IMASK_OFS, 32'h0);
    wr(EMASK_OFS, 32'h4);
    n_evt = 0;
    ext.pulse(2);
    cyc(5);
    chk(n_evt, 1);
    rdchk(PEND_OFS, 32'h0);
    wr(EMASK_OFS, 32'h0);
    wr(FALL_OFS, 32'h0);
    wr(RISE_OFS, 32'h7FFFF);
    wr(IMASK_OFS, 32'hFFFF);
  endtask

  task automatic t_sleep;
    wr(CTRL_OFS, 32'h2);
    cyc(2);
    chk(pwr.cpu_clk_en, 1'b1);
    wr(CTRL_OFS, 32'h3);
    cyc(2);
    chk({pwr.cpu_clk_en, pwr.core_clk_en}, 2'b01);
    periph_irq <= 1'b1;
    cyc(3);
    chk(pwr.cpu_clk_en, 1'b1);
    periph_irq <= 1'b0;
  endtask

  task automatic t_stop;
    wr(CTRL_OFS, 32'h15);
    cyc(2);
    chk({pwr.core_clk_en, pwr.pll_en, pwr.int_osc_en, pwr.ext_osc_en}, 4'h0);
    chk({pwr.reg_en, pwr.reg_lp}, 2'b11);
    ext.pulse(3);
    for (int k = 0; k < 20 && pwr.core_clk_en !== 1'b1; k++) cyc(1);
    chk({pwr.core_clk_en, pwr.int_osc_en, pwr.sysclk_ext}, 3'b110);
    rdchk(ISTAT_OFS, 32'h1 << IRQ_STOP_WK);
    rdchk(RISE_OFS, 32'h7FFFF);
    wr(ISTAT_OFS, 32'h1F);
    wr(PEND_OFS, 32'h7FFFF);
  endtask

  task automatic t_clock_fail;
    ext.osc_run <= 1'b1;
    cyc(3);
    wr(CTRL_OFS, 32'h60);
    cyc(3);
    chk(pwr.sysclk_ext, 1'b1);
    rdchk(STAT_OFS, 32'h14);
    ext.osc_run <= 1'b0;
    cyc(CSS + 6);
    chk({pwr.sysclk_ext, pwr.int_osc_en}, 2'b01);
    rdchk(ISTAT_OFS, 32'h1 << IRQ_CLK_FAIL);
    rdchk(CTRL_OFS, 32'h40);
    wr(ISTAT_OFS, 32'h1F);
  endtask

  task automatic t_standby;
    wr(CTRL_OFS, 32'h7);
    cyc(2);
    chk({pwr.reg_en, pwr.core_pwr_en, pwr.int_osc_en, pwr.pll_en}, 4'h0);
    ext.pulse(3);
    cyc(6);
    chk(pwr.reg_en, 1'b0);
    standby_wake_pin <= 1'b1;
    for (int k = 0; k < 10 && sys_reset_n !== 1'b0; k++) cyc(1);
    for (int k = 0; k < 20 && sys_reset_n !== 1'b1; k++) cyc(1);
    chk({sys_reset_n, pwr.reg_en}, 2'b11);
    standby_wake_pin <= 1'b0;
    rdchk(RISE_OFS, 32'h0);
    rdchk(ISTAT_OFS, 32'h1 << IRQ_STBY_WK);
    wr(ISTAT_OFS, 32'h1F);
    // Second and third exits: reset pin low, then watchdog reset
    for (int s = 0; s < 2; s++) begin
      wr(CTRL_OFS, 32'h7);
      cyc(2);
      if (s == 0) rst_pin_n <= 1'b0;
      else wdog_rst <= 1'b1;
      cyc(1);
      rst_pin_n <= 1'b1;
      wdog_rst  <= 1'b0;
      for (int k = 0; k < 20 && sys_reset_n !== 1'b1; k++) cyc(1);
      chk({sys_reset_n, pwr.reg_en}, 2'b11);
      rdchk(ISTAT_OFS, 32'h1 << IRQ_STBY_WK);
      wr(ISTAT_OFS, 32'h1F);
    end
  endtask

  task automatic t_supply;
    wr(IMSK_OFS, 32'h1);
    wr(CTRL_OFS, 32'h8);
    ext.set_line(16, 1'b1);
    cyc(5);
    chk({irq, pwr.det_en}, 2'b11);
    rdchk(ISTAT_OFS, 32'h1);
    wr(IMSK_OFS, 32'h0);
    cyc(1);
    chk(irq, 1'b0);
    wr(ISTAT_OFS, 32'h1);
    ext.set_line(16, 1'b0);
    cyc(5);
    rdchk(ISTAT_OFS, 32'h2);
    supply_ok <= 1'b0;
    cyc(3);
    chk(sys_reset_n, 1'b0);
    supply_ok <= 1'b1;
    cyc(3);
    chk(sys_reset_n, 1'b1);
    // With the clock enable low an entry write must not take
    ce <= 1'b0;
    wr(CTRL_OFS, 32'h3);
    cyc(2);
    chk(pwr.cpu_clk_en, 1'b1);
    ce <= 1'b1;
    cyc(2);
    chk(pwr.cpu_clk_en, 1'b1);
  endtask

  task automatic finish_test;
    $display("mismatches %0d, comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    #2000000;
    n_mismatch++;
    finish_test();
  end

  initial begin
    hresetn = 1'b0; hsel = 1'b1; htrans = 2'h0; hwrite = 1'b0; haddr = '0; hwdata = '0;
    supply_ok = 1'b1; standby_wake_pin = 1'b0; periph_irq = 1'b0;
    ce = 1'b1; rst_pin_n = 1'b1; wdog_rst = 1'b0;
    n_mismatch = 0; checked = 0; n_evt = 0;
    cyc(4);
    hresetn <= 1'b1;
    cyc(2);
    t_reset();
    t_lines();
    t_sleep();
    t_stop();
    t_clock_fail();
    t_standby();
    t_supply();
    finish_test();
  end
endmodule
